/* sim/tb_top.sv */
// self-checking bench for the pwm timer channel
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR %0t got %h exp %h", $time, g, e); end end
module tb_top
  import tpm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // stimulus and observed signals
  // ----
  logic        mclk = 0, rst = 1, psel = 0, odis = 0, run = 0, m8 = 0, trg_en = 0;
  logic [1:0]  alt = 0, tsel = 0, f_sel = 0;
  logic [2:0]  osel = 0;
  logic        slow = 0, sub = 0, wr = 0, en = 1, inv = 0, f_stb = 0;
  logic [15:0] wdat = 0, rdat;
  logic        trg_pin, oth, prv, nxt, pout, oe_n, irq, running;
  logic        pin_q = 0, have_r = 0;
  logic [31:0] seed = 32'h717B3C76;
  int          error_cnt = 0, checks_done = 0, cyc = 0, rise_c = 0, dv = 1, e;
  int          exp_w[$], exp_p[$];

  always #5 mclk = ~mclk;
  // slow clocks toggle between edges: period 8 and 4 cycles
  always #40 slow = ~slow;
  always #20 sub = ~sub;

  tpm_channel DUT (
    .MCLK_I(mclk), .SYS_RST_I(rst), .PRESCALE_SEL_I(psel), .SRC_OPT_DIS_I(odis),
    .ALT_SRC_SEL_I(alt), .OPT_SRC_SEL_I(osel), .SLOW_OSC_CLK_I(slow),
    .SUBCLK_I(sub), .RUN_BIT_I(run), .MODE_8BIT_I(m8), .TRIG_ENABLE_I(trg_en),
    .TRIG_SEL_I(tsel), .TRIG_IN_I(trg_pin), .OTHER_UFLOW_I(oth),
    .PREV_UFLOW_I(prv), .NEXT_UFLOW_I(nxt), .WR_STB_I(wr), .WR_DATA_I(wdat),
    .PULSE_OUT_EN_I(en), .POL_INV_I(inv), .PULSE_OUT_O(pout),
    .PULSE_OE_N_O(oe_n), .IRQ_O(irq), .RUNNING_O(running), .RD_DATA_O(rdat)
  );

  tpm_far_model FAR (
    .clk_i(mclk), .fire_i(f_stb), .sel_i(f_sel), .trig_pin_o(trg_pin),
    .other_o(oth), .prev_o(prv), .next_o(nxt)
  );

  // ----
  // helpers
  // ----
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask : tick

  task automatic note(input int w, input int p);
    if (w > 0) exp_w.push_back(w);
    if (p > 0) exp_p.push_back(p);
  endtask : note

  task automatic wr_cnt(input logic [15:0] d);
    wdat = d;
    wr = 1;
    tick(1);
    wr = 0;
  endtask : wr_cnt

  task automatic fire(input logic [1:0] s);
    f_sel = s;
    f_stb = 1;
    tick(1);
    f_stb = 0;
  endtask : fire

  task automatic wait_irq(input int k);
    int t;
    t = 0;
    while (k > 0 && t < 70000) begin
      tick(1);
      t++;
      if (irq === 1'b1) k--;
    end
    `CHK(k, 0)
  endtask : wait_irq

  task automatic start_run();
    run = 1;
    tick(1);
    `CHK(running, 1'b0)
    tick(1);
    `CHK(running, 1'b1)
  endtask : start_run

  task automatic stop_run();
    run = 0;
    tick(4);
    `CHK(running, 1'b0)
    `CHK(pout, 1'b0)
  endtask : stop_run

  // ----
  // monitor: pulse width at each interrupt, period at each later rise
  // ----
  // sampled mid-cycle, where the registered outputs have settled
  always @(negedge mclk) begin
    cyc++;
    if (cyc == 90000) begin
      error_cnt++;
      final_report();
    end
    if (running !== 1'b1) have_r = 0;
    if (pout === 1'b1 && pin_q !== 1'b1) begin
      if (have_r) begin
        e = exp_p.size() ? exp_p.pop_front() : -1;
        `CHK(cyc - rise_c, e)
      end
      have_r = 1;
      rise_c = cyc;
    end
    if (irq === 1'b1) begin
      e = exp_w.size() ? exp_w.pop_front() : -1;
      // irq leads the pin fall by one cycle; first tick phase unknown, round up
      `CHK((cyc - rise_c + dv) / dv, e)
    end
    pin_q = pout;
  end

  // ----
  // main sequence
  // ----
  initial begin
    logic [7:0] n;
    tick(1);
    `CHK(pout, 1'b0)
    `CHK(oe_n, 1'b1)
    `CHK(running, 1'b0)
    tick(1);
    rst = 0;
    inv = 1;
    tick(2);
    `CHK(pout, 1'b1)
    en = 0;
    tick(2);
    `CHK(pout, 1'b0)
    `CHK(oe_n, 1'b1)
    en = 1;
    inv = 0;
    tick(2);
    `CHK(oe_n, 1'b0)
    $display("test pin levels done");

    wr_cnt(16'h0003);
    note(3, (1 << 16) - 1);
    note(3, 0);
    start_run();
    wait_irq(2);
    stop_run();
    $display("test wide mode done");

    seed = lfsr(seed);
    n = {3'h0, seed[4:0]} + 8'h02;
    m8 = 1;
    wr_cnt({n, 8'h00});
    note(n, (1 << 8) - 1);
    note(n, 0);
    start_run();
    wait_irq(2);
    // new value lands only at the next reload
    wr_cnt(16'h2001);
    note(16'h20 * 2, (1 << 8) - 1);
    note(16'h20 * 2, ((1 << 8) - 1) * 2);
    wait_irq(2);
    stop_run();
    $display("test narrow mode done");

    m8 = 0;
    for (int i = 0; i < 6; i++) begin
      psel = i == 0;
      odis = i > 3;
      alt = 2'(i);
      osel = i == 5 ? TPM_OPT_SUB32 : TPM_OPT_SLOW;
      wr_cnt(16'h0003);
      dv = i == 0 ? 2 : i == 1 ? 8 : i == 2 ? 32 : i == 3 ? 64 : i == 4 ? 8 : 128;
      note(3, 0);
      run = 1;
      wait_irq(1);
      stop_run();
      dv = 1;
    end
    odis = 0;
    alt = 0;
    psel = 0;
    $display("test count sources done");

    m8 = 1;
    trg_en = 1;
    wr_cnt(16'h4000);
    for (int s = 0; s < 4; s++) begin
      tsel = 2'(s);
      run = 1;
      fire(2'(s + 1));
      tick(4);
      `CHK(running, 1'b0)
      note(16'h40, 0);
      fire(2'(s));
      tick(4);
      `CHK(running, 1'b1)
      fire(2'(s));
      wait_irq(1);
      stop_run();
    end
    trg_en = 0;
    $display("test triggers done");
    tick(2);
    `CHK(exp_w.size() + exp_p.size(), 0)
    final_report();
  end
endmodule : tb_top

/* sim/tpm_far_model.sv */
// far-side model: trigger pin and neighbour-timer underflow pulses
module tpm_far_model
  import tpm_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       fire_i,
  input  wire logic [1:0] sel_i,
  output logic            trig_pin_o,
  output logic            other_o,
  output logic            prev_o,
  output logic            next_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] hold_r = 2'h0;
  // underflows are one-cycle pulses; the pin stays high 3 cycles so edges are slow
  always @(posedge clk_i) begin
    other_o <= fire_i && sel_i == TPM_TRG_OTHER;
    prev_o <= fire_i && sel_i == TPM_TRG_PREV;
    next_o <= fire_i && sel_i == TPM_TRG_NEXT;
    if (fire_i && sel_i == TPM_TRG_PIN) begin
      hold_r <= 2'h3;
    end else if (hold_r != 2'h0) begin
      hold_r <= hold_r - 2'h1;
    end
  end
  assign trig_pin_o = hold_r != 2'h0;
endmodule : tpm_far_model

/* verilog/tpm_channel.sv */
// pwm mode of a down-counting timer channel, with start and output logic

// What this block does
// - counts one selected source: timer clock /1 or /2, /8, /32, /64, slow osc, sub/32
// - counter decrements; runs as 16-bit or 8-bit pulse width modulator
// - every rising pulse edge reloads the counter and counting continues
// - once counting, further triggers have no effect at all
// - 16-bit mode: high time is n count source periods
// - 16-bit mode: period is fixed at 65535 count source periods
// - 8-bit mode: high time is upper byte n times (m+1) periods
// - 8-bit mode: period is 255 times (m+1) periods, m the lower byte
// - with no trigger selected, counting starts when the run bit is 1
// - with pin trigger selected, a pin trigger starts counting while run bit is 1
// - other-family timer, previous or next channel underflow may start counting
// - counting stops only when software clears the run bit
// - interrupt request on each counted falling edge of the pulse; a stop clears the pulse without one
// - reading the count register gives an undefined value
// - stopped write loads reload and counter; running write loads reload only
// - inverted polarity drives the output pin high while stopped
// - trigger pin is the source only when trigger select bits are 00b
// - waveform reaches the pin only when pulse output enable is 1
// - normal source choice applies only while the option disable bit is 0
// - prescale select bit picks undivided or half timer clock as lowest source
module tpm_channel
  import tpm_pkg::*;
(
  input  wire logic        MCLK_I,
  input  wire logic        SYS_RST_I,
  input  wire logic        PRESCALE_SEL_I,
  input  wire logic        SRC_OPT_DIS_I,
  input  wire logic [1:0]  ALT_SRC_SEL_I,
  input  wire logic [2:0]  OPT_SRC_SEL_I,
  input  wire logic        SLOW_OSC_CLK_I,
  input  wire logic        SUBCLK_I,
  input  wire logic        RUN_BIT_I,
  input  wire logic        MODE_8BIT_I,
  input  wire logic        TRIG_ENABLE_I,
  input  wire logic [1:0]  TRIG_SEL_I,
  input  wire logic        TRIG_IN_I,
  input  wire logic        OTHER_UFLOW_I,
  input  wire logic        PREV_UFLOW_I,
  input  wire logic        NEXT_UFLOW_I,
  input  wire logic        WR_STB_I,
  input  wire logic [15:0] WR_DATA_I,
  input  wire logic        PULSE_OUT_EN_I,
  input  wire logic        POL_INV_I,
  output logic             PULSE_OUT_O,
  output logic             PULSE_OE_N_O,
  output logic             IRQ_O,
  output logic             RUNNING_O,
  output logic [15:0]      RD_DATA_O
);

  // ----------------------------------------------------------------
  // count source
  // ----------------------------------------------------------------
  logic tick;

  tpm_count_src u_src (
    .clk_i          (MCLK_I),
    .rst_i          (SYS_RST_I),
    .prescale_sel_i (PRESCALE_SEL_I),
    .src_opt_dis_i  (SRC_OPT_DIS_I),
    .alt_src_sel_i  (ALT_SRC_SEL_I),
    .opt_src_sel_i  (OPT_SRC_SEL_I),
    .slow_osc_i     (SLOW_OSC_CLK_I),
    .subclk_i       (SUBCLK_I),
    .tick_o         (tick)
  );

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  tpm_state_t  state_r;
  tpm_state_t  state_nxt;
  logic [15:0] reload_r;
  logic [15:0] per_r;
  logic [15:0] wid_r;
  logic [15:0] wid_ld_r;
  logic [7:0]  pre_r;
  logic [7:0]  pre_ld_r;
  logic        pwm_r;
  logic        trig_q_r;
  logic        trig_ev;
  logic        start_ev;
  logic        step_ev;
  logic        reload_ev;
  logic        fall_ev;
  logic        counting;
  logic [15:0] period_v;
  logic [15:0] width_v;
  logic [7:0]  presc_v;

  assign counting = (state_r == TPM_COUNT);

  // ----------------------------------------------------------------
  // trigger selection
  // ----------------------------------------------------------------
  // pin trigger is taken on its rising edge; the pin is synchronous
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      trig_q_r <= 1'b0;
    end else begin
      trig_q_r <= TRIG_IN_I;
    end
  end

  always_comb begin
    case (TRIG_SEL_I)
      TPM_TRG_PIN:   trig_ev = TRIG_IN_I & ~trig_q_r;
      TPM_TRG_OTHER: trig_ev = OTHER_UFLOW_I;
      TPM_TRG_PREV:  trig_ev = PREV_UFLOW_I;
      TPM_TRG_NEXT:  trig_ev = NEXT_UFLOW_I;
      default:       trig_ev = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      TPM_IDLE: begin
        if (RUN_BIT_I) begin
          state_nxt = TRIG_ENABLE_I ? TPM_ARMED : TPM_COUNT;
        end
      end
      TPM_ARMED: begin
        if (!RUN_BIT_I) begin
          state_nxt = TPM_IDLE;
        end else if (!TRIG_ENABLE_I || trig_ev) begin
          state_nxt = TPM_COUNT;
        end
      end
      TPM_COUNT: begin
        // trigger deliberately not looked at here
        if (!RUN_BIT_I) begin
          state_nxt = TPM_IDLE;
        end
      end
      default: state_nxt = TPM_IDLE;
    endcase
  end

  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      state_r <= TPM_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign start_ev = !counting && (state_nxt == TPM_COUNT);

  // ----------------------------------------------------------------
  // mode geometry
  // ----------------------------------------------------------------
  always_comb begin
    if (MODE_8BIT_I) begin
      period_v = TPM_PERIOD8;
      width_v  = {8'h00, reload_r[15:TPM_HI_BYTE]};
      presc_v  = reload_r[TPM_HI_BYTE-1:0];
    end else begin
      period_v = TPM_PERIOD16;
      width_v  = reload_r;
      presc_v  = 8'h00;
    end
  end

  // a step is one source period in 16-bit mode, m+1 periods in 8-bit
  assign step_ev   = counting && tick && (!MODE_8BIT_I || pre_r == 8'h00);
  assign reload_ev = step_ev && (per_r == 16'h0000);
  assign fall_ev   = step_ev && !reload_ev && pwm_r && (wid_r == 16'h0001);

  // ----------------------------------------------------------------
  // reload register
  // ----------------------------------------------------------------
  // stopped writes also reach the counter, since a start loads from here
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      reload_r <= TPM_RST_RELOAD;
    end else if (WR_STB_I) begin
      reload_r <= WR_DATA_I;
    end
  end

  // ----------------------------------------------------------------
  // counters
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      per_r    <= 16'h0000;
      wid_r    <= 16'h0000;
      wid_ld_r <= 16'h0000;
      pre_r    <= 8'h00;
      pre_ld_r <= 8'h00;
    end else if (start_ev || reload_ev) begin
      per_r    <= period_v - 16'h0001;
      wid_r    <= width_v;
      wid_ld_r <= width_v;
      pre_r    <= presc_v;
      pre_ld_r <= presc_v;
    end else if (!counting && WR_STB_I) begin
      wid_r    <= MODE_8BIT_I ? {8'h00, WR_DATA_I[15:TPM_HI_BYTE]} : WR_DATA_I;
      wid_ld_r <= wid_ld_r;
    end else if (counting && tick) begin
      if (MODE_8BIT_I) begin
        // prescaler reloads from latched m: a running write waits for the next reload
        pre_r <= (pre_r == 8'h00) ? pre_ld_r : pre_r - 8'h01;
      end
      if (step_ev) begin
        per_r <= per_r - 16'h0001;
        if (wid_r != 16'h0000) begin
          wid_r <= wid_r - 16'h0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // pulse level
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      pwm_r <= 1'b0;
    end else if (state_nxt != TPM_COUNT) begin
      pwm_r <= 1'b0;
    end else if (start_ev || reload_ev) begin
      pwm_r <= (width_v != 16'h0000);
    end else if (fall_ev) begin
      pwm_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // stopping clears pwm_r without a falling-edge request
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= fall_ev && RUN_BIT_I;
    end
  end

  // pin is released, not driven, while the pulse output is disabled
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      PULSE_OUT_O  <= 1'b0;
      PULSE_OE_N_O <= 1'b1;
    end else begin
      PULSE_OUT_O  <= PULSE_OUT_EN_I & (pwm_r ^ POL_INV_I);
      PULSE_OE_N_O <= ~PULSE_OUT_EN_I;
    end
  end

  // read value carries no meaning in this mode; software must ignore it
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      RD_DATA_O <= 16'h0000;
      RUNNING_O <= 1'b0;
    end else begin
      RD_DATA_O <= per_r;
      RUNNING_O <= counting;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [15:0] hi_cnt_r;
  logic [15:0] stp_cnt_r;

  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I || start_ev || reload_ev) begin
      hi_cnt_r  <= 16'h0000;
      stp_cnt_r <= 16'h0000;
    end else if (step_ev) begin
      stp_cnt_r <= stp_cnt_r + 16'h0001;
      if (pwm_r) begin
        hi_cnt_r <= hi_cnt_r + 16'h0001;
      end
    end
  end

  sequence run_steady_s;
    counting && RUN_BIT_I;
  endsequence

  sequence counted_fall_s;
    $fell(pwm_r) ##0 counting ##0 $past(counting);
  endsequence

  start_notrig_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    (state_r == TPM_IDLE && RUN_BIT_I && !TRIG_ENABLE_I) |=> counting)
    else $error("no start after run bit set");

  pin_trig_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    (state_r == TPM_ARMED && RUN_BIT_I && TRIG_SEL_I == TPM_TRG_PIN
     && TRIG_IN_I && !trig_q_r) |=> counting ##1 $rose(RUNNING_O))
    else $error("pin trigger did not start counting");

  trig_ignored_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    (run_steady_s ##0 (trig_ev && per_r != 16'h0000))
    |=> counting && !start_ev && ($past(per_r) - per_r <= 16'h0001))
    else $error("trigger disturbed running counter");

  stop_clear_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    !RUN_BIT_I |=> !counting ##1 !RUNNING_O)
    else $error("counter ran with run bit clear");

  irq_fall_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    (counted_fall_s ##0 $past(RUN_BIT_I)) |-> IRQ_O)
    else $error("no request on falling pulse edge");

  rise_reload_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    $rose(pwm_r) |-> $past(start_ev || reload_ev))
    else $error("pulse rose without reload");

  pulse_width_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    counted_fall_s |-> (hi_cnt_r == wid_ld_r))
    else $error("high time differs from programmed width");

  cycle_len_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    reload_ev |-> (16'(stp_cnt_r + 16'h0001) == period_v))
    else $error("period differs from fixed length");

  write_run_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    (WR_STB_I && counting && !reload_ev && RUN_BIT_I)
    |=> $stable(wid_ld_r) && ($past(wid_r) - wid_r <= 16'h0001))
    else $error("running write reached the counter");

  inv_stop_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    (!counting && POL_INV_I && PULSE_OUT_EN_I) |=> PULSE_OUT_O)
    else $error("inverted output not high while stopped");

  out_enable_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    !PULSE_OUT_EN_I |=> (!PULSE_OUT_O && PULSE_OE_N_O))
    else $error("pulse reached pin while disabled");

endmodule : tpm_channel

/* verilog/tpm_count_src.sv */
// count source tick generator for the pwm timer channel
module tpm_count_src
  import tpm_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       prescale_sel_i,
  input  wire logic       src_opt_dis_i,
  input  wire logic [1:0] alt_src_sel_i,
  input  wire logic [2:0] opt_src_sel_i,
  input  wire logic       slow_osc_i,
  input  wire logic       subclk_i,
  output logic            tick_o
);

  logic [5:0] div_r;
  logic [4:0] sub_div_r;
  logic       slow_q_r;
  logic       sub_q_r;
  logic       slow_rise;
  logic       sub_rise;
  logic       tick_nxt;

  assign slow_rise = slow_osc_i & ~slow_q_r;
  assign sub_rise  = subclk_i & ~sub_q_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_r <= 6'h00;
    end else begin
      div_r <= div_r + 6'h01;
    end
  end

  // slow clocks arrive as synchronous levels; edges become ticks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slow_q_r  <= 1'b0;
      sub_q_r   <= 1'b0;
      sub_div_r <= 5'h00;
    end else begin
      slow_q_r <= slow_osc_i;
      sub_q_r  <= subclk_i;
      if (sub_rise) begin
        sub_div_r <= sub_div_r + 5'h01;
      end
    end
  end

  always_comb begin
    tick_nxt = 1'b0;
    if (!src_opt_dis_i) begin
      case (alt_src_sel_i)
        TPM_ALT_F1:  tick_nxt = prescale_sel_i ? div_r[0] : 1'b1;
        TPM_ALT_F8:  tick_nxt = &div_r[2:0];
        TPM_ALT_F32: tick_nxt = &div_r[4:0];
        TPM_ALT_F64: tick_nxt = &div_r;
        default:     tick_nxt = 1'b0;
      endcase
    end else begin
      case (opt_src_sel_i)
        TPM_OPT_SLOW:  tick_nxt = slow_rise;
        TPM_OPT_SUB32: tick_nxt = sub_rise && (sub_div_r == TPM_SUB_DIV_LAST);
        default:       tick_nxt = 1'b0; // unused codes give no source
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= tick_nxt;
    end
  end

endmodule : tpm_count_src

/* verilog/tpm_pkg.sv */
// shared constants and types for the pwm timer channel
package tpm_pkg;

  // ----------------------------------------------------------------
  // waveform geometry
  // ----------------------------------------------------------------
  localparam logic [15:0] TPM_PERIOD16 = 16'hFFFF; // 2^16 - 1 steps
  localparam logic [15:0] TPM_PERIOD8  = 16'h00FF; // 2^8 - 1 steps
  localparam int          TPM_HI_BYTE  = 8;        // pulse count in 8-bit mode
  localparam logic [15:0] TPM_RST_RELOAD = 16'h0000;

  // ----------------------------------------------------------------
  // count source selection codes
  // ----------------------------------------------------------------
  localparam logic [1:0] TPM_ALT_F1 = 2'h0;
  localparam logic [1:0] TPM_ALT_F8 = 2'h1;
  localparam logic [1:0] TPM_ALT_F32 = 2'h2;
  localparam logic [1:0] TPM_ALT_F64 = 2'h3;
  localparam logic [2:0] TPM_OPT_SLOW = 3'h5;
  localparam logic [2:0] TPM_OPT_SUB32 = 3'h6;
  localparam logic [4:0] TPM_SUB_DIV_LAST = 5'h1F; // subclock / 32

  // ----------------------------------------------------------------
  // trigger source codes (high bit, low bit)
  // ----------------------------------------------------------------
  localparam logic [1:0] TPM_TRG_PIN = 2'h0;
  localparam logic [1:0] TPM_TRG_OTHER = 2'h1;
  localparam logic [1:0] TPM_TRG_PREV = 2'h2;
  localparam logic [1:0] TPM_TRG_NEXT = 2'h3;

  typedef enum logic [1:0] {
    TPM_IDLE  = 2'b00,
    TPM_ARMED = 2'b01,
    TPM_COUNT = 2'b10
  } tpm_state_t;

endpackage : tpm_pkg
